// [design/rco_pkg.sv]
package rco_pkg;

	// ==========================================================
	// register map
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] RSVD_MASK = 32'h8000_44F0;

	// ==========================================================
	// field positions of the control register
	localparam int DIV_LSB = 16;
	localparam int DIV_W = 15;
	localparam int ON_BIT = 15;
	localparam int STOP_IN_IDLE_BIT = 13;
	localparam int OE_BIT = 12;
	localparam int RUN_IN_SLEEP_BIT = 11;
	localparam int SWREQ_BIT = 9;
	localparam int ACTIVE_BIT = 8;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;

	// ==========================================================
	// source codes that stop in sleep whatever the run bit says
	localparam logic [3:0] SEL_SLEEP_STOP_MAX = 4'h1;

	// ==========================================================
	// bus and sources
	localparam int ADDR_W = 12;
	localparam int NUM_SRC = 16;
	localparam int SYNC_STAGES = 2;

endpackage

// [design/rco_div.sv]
`timescale 1ns/1ps

module rco_div #(
	parameter int DIV_W = 15
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// control
	input wire logic run,
	input wire logic tick,
	input wire logic [DIV_W-1:0] half_period,
	// result
	output logic level,
	output logic boundary
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic level;
	} rco_div_s;

	rco_div_s st_q;
	rco_div_s st_d;
	logic [DIV_W-1:0] limit;
	logic wrap;

	// a zero divider still toggles on every source edge
	assign limit = (half_period == '0) ? DIV_W'(1) : half_period;
	assign wrap = (st_q.cnt + DIV_W'(1)) >= limit;
	// falling edge of the output is the safe switch point while the generator runs
	assign boundary = run & tick & wrap & st_q.level;
	assign level = st_q.level;

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;
		if (!run) begin
			// stop low so the pin never rests high
			st_d.cnt = '0;
			st_d.level = 1'b0;
		end else if (tick) begin
			if (wrap) begin
				st_d.cnt = '0;
				st_d.level = ~st_q.level;
			end else begin
				st_d.cnt = st_q.cnt + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// checks
	property p_div_stops_low;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !run |=> !level;
	endproperty
	a_div_stops_low: assert property (p_div_stops_low)
		else $error("divider output not low after stop");

	property p_div_only_on_tick;
		@(posedge pclk) disable iff (!presetn)
		clk_en && run && !tick |=> $stable(level);
	endproperty
	a_div_only_on_tick: assert property (p_div_only_on_tick)
		else $error("divider output moved without a source edge");

endmodule

// [design/rco_ctrl.sv]
`timescale 1ns/1ps

module rco_ctrl #(
	parameter int NUM_SRC = rco_pkg::NUM_SRC
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rco_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// power modes, same clock domain
	input wire logic idle_mode,
	input wire logic sleep_mode,
	// candidate source clocks, asynchronous
	input wire logic [NUM_SRC-1:0] src_clk_in,
	// reference clock pin
	output logic ref_clock_out_pin,
	output logic ref_clock_out_oe
);

	localparam int DW = rco_pkg::DIV_W;
	localparam int SW = rco_pkg::SEL_W;

	// ==========================================================
	// state
	typedef struct packed {
		logic [DW-1:0] div;
		logic on;
		logic stop_in_idle;
		logic oe;
		logic run_in_sleep;
		logic swreq;
		logic [SW-1:0] sel;
		logic [DW-1:0] div_act;
		logic [SW-1:0] sel_act;
		logic [NUM_SRC-1:0] sync1;
		logic [NUM_SRC-1:0] sync2;
		logic [NUM_SRC-1:0] sync3;
		logic [31:0] rdata;
		logic pin;
		logic pin_oe;
	} rco_ctrl_s;

	rco_ctrl_s st_q;
	rco_ctrl_s st_d;

	logic wr_ctrl;
	logic rd_setup;
	logic hit;
	logic tick;
	logic run;
	logic sleep_stop;
	logic apply;
	logic ref_lvl;
	logic boundary;
	logic active;
	logic [31:0] ctrl_view;

	// ==========================================================
	// bus decode
	assign hit = (paddr == rco_pkg::CTRL_ADDR);
	// zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_ctrl = psel & penable & pwrite & hit & clk_en;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign prdata = st_q.rdata;

	// ==========================================================
	// generator control
	// sources numbered 0 and 1 die in sleep, so the run bit cannot help
	assign sleep_stop = sleep_mode &
		(~st_q.run_in_sleep | (st_q.sel_act <= rco_pkg::SEL_SLEEP_STOP_MAX));
	assign run = st_q.on
		& ~(idle_mode & st_q.stop_in_idle)
		& ~sleep_stop;
	// rising edge of the selected, resynchronised source
	assign tick = st_q.sync2[st_q.sel_act] & ~st_q.sync3[st_q.sel_act];
	// a stopped generator rests low, so switching then is glitch free
	assign apply = st_q.swreq & (boundary | ~run);
	// request stays up until the output has fallen back low
	assign active = st_q.on | ref_lvl;

	rco_div #(
		.DIV_W(DW)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.run(run),
		.tick(tick),
		.half_period(st_q.div_act),
		.level(ref_lvl),
		.boundary(boundary)
	);

	// ==========================================================
	// register view, unimplemented bits stay zero
	always_comb begin
		ctrl_view = '0;
		ctrl_view[rco_pkg::DIV_LSB +: DW] = st_q.div;
		ctrl_view[rco_pkg::ON_BIT] = st_q.on;
		ctrl_view[rco_pkg::STOP_IN_IDLE_BIT] = st_q.stop_in_idle;
		ctrl_view[rco_pkg::OE_BIT] = st_q.oe;
		ctrl_view[rco_pkg::RUN_IN_SLEEP_BIT] = st_q.run_in_sleep;
		ctrl_view[rco_pkg::SWREQ_BIT] = st_q.swreq;
		ctrl_view[rco_pkg::ACTIVE_BIT] = active;
		ctrl_view[rco_pkg::SEL_LSB +: SW] = st_q.sel;
	end

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;
		st_d.sync1 = src_clk_in;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = st_q.sync2;
		if (rd_setup) begin
			st_d.rdata = hit ? ctrl_view : '0;
		end
		// hardware clear first so a new request in the same cycle wins
		if (apply) begin
			st_d.swreq = 1'b0;
			st_d.div_act = st_q.div;
			st_d.sel_act = st_q.sel;
		end
		if (wr_ctrl) begin
			if (pstrb[3]) begin
				st_d.div[DW-1:8] = pwdata[30:24];
			end
			if (pstrb[2]) begin
				st_d.div[7:0] = pwdata[23:16];
			end
			if (pstrb[1]) begin
				st_d.on = pwdata[rco_pkg::ON_BIT];
				st_d.stop_in_idle = pwdata[rco_pkg::STOP_IN_IDLE_BIT];
				st_d.oe = pwdata[rco_pkg::OE_BIT];
				st_d.run_in_sleep = pwdata[rco_pkg::RUN_IN_SLEEP_BIT];
				if (pwdata[rco_pkg::SWREQ_BIT]) begin
					st_d.swreq = 1'b1;
				end
			end
			if (pstrb[0]) begin
				st_d.sel = pwdata[rco_pkg::SEL_LSB +: SW];
			end
			// a disabled module takes new settings at once
			if (!st_q.on) begin
				st_d.div_act = st_d.div;
				st_d.sel_act = st_d.sel;
			end
		end
		st_d.pin = ref_lvl & st_q.oe;
		st_d.pin_oe = st_q.oe;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign ref_clock_out_pin = st_q.pin;
	assign ref_clock_out_oe = st_q.pin_oe;

	// ==========================================================
	// checks
	property p_off_no_clock;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !st_q.on |=> !ref_lvl;
	endproperty
	a_off_no_clock: assert property (p_off_no_clock)
		else $error("generator ran while disabled");

	property p_idle_stop;
		@(posedge pclk) disable iff (!presetn)
		clk_en && idle_mode && st_q.stop_in_idle |=> !ref_lvl;
	endproperty
	a_idle_stop: assert property (p_idle_stop)
		else $error("generator ran in idle with stop-in-idle set");

	property p_idle_run;
		@(posedge pclk) disable iff (!presetn)
		st_q.on && idle_mode && !st_q.stop_in_idle && !sleep_mode |-> run;
	endproperty
	a_idle_run: assert property (p_idle_run)
		else $error("generator stopped in idle without stop-in-idle");

	property p_pin_gated;
		@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en |->
			ref_clock_out_pin == ($past(ref_lvl) && $past(st_q.oe));
	endproperty
	a_pin_gated: assert property (p_pin_gated)
		else $error("pin level does not follow generator and enable");

	property p_sleep_stop;
		@(posedge pclk) disable iff (!presetn)
		clk_en && sleep_mode && !st_q.run_in_sleep |=> !ref_lvl;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop)
		else $error("generator ran in sleep without run-in-sleep");

	property p_sleep_low_sel;
		@(posedge pclk) disable iff (!presetn)
		clk_en && sleep_mode &&
			st_q.sel_act <= rco_pkg::SEL_SLEEP_STOP_MAX |=> !ref_lvl;
	endproperty
	a_sleep_low_sel: assert property (p_sleep_low_sel)
		else $error("run-in-sleep honoured for a low source code");

	property p_swreq_clears;
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.swreq && !run && !wr_ctrl |=> !st_q.swreq;
	endproperty
	a_swreq_clears: assert property (p_swreq_clears)
		else $error("switch request not cleared while stopped");

	property p_div_held;
		@(posedge pclk) disable iff (!presetn)
		clk_en && st_q.on && !apply |=>
			$stable(st_q.div_act) && $stable(st_q.sel_act);
	endproperty
	a_div_held: assert property (p_div_held)
		else $error("active settings changed without a switch");

	property p_active_on;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rd_setup && hit && st_q.on |=>
			prdata[rco_pkg::ACTIVE_BIT];
	endproperty
	a_active_on: assert property (p_active_on)
		else $error("request status low while enabled");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		(prdata & rco_pkg::RSVD_MASK) == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("unimplemented bit read as one");

	property p_switch_at_low;
		@(posedge pclk) disable iff (!presetn)
		clk_en && apply |=> !ref_lvl;
	endproperty
	a_switch_at_low: assert property (p_switch_at_low)
		else $error("settings switched while output high");

	property p_oe_follows;
		@(posedge pclk) disable iff (!presetn)
		clk_en |=> ref_clock_out_oe == $past(st_q.oe);
	endproperty
	a_oe_follows: assert property (p_oe_follows)
		else $error("pin enable does not follow the enable bit");

	property p_pin_off;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !st_q.oe |=> !ref_clock_out_pin;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("pin high while output enable clear");

	property p_swreq_set;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && pstrb[1] && pwdata[rco_pkg::SWREQ_BIT] |=> st_q.swreq;
	endproperty
	a_swreq_set: assert property (p_swreq_set)
		else $error("switch request lost against hardware clear");

	property p_active_low;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rd_setup && hit && !st_q.on && !ref_lvl |=>
			!prdata[rco_pkg::ACTIVE_BIT];
	endproperty
	a_active_low: assert property (p_active_low)
		else $error("request status high with no request");

	property p_off_loads;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && !st_q.on |=>
			st_q.div_act == st_q.div && st_q.sel_act == st_q.sel;
	endproperty
	a_off_loads: assert property (p_off_loads)
		else $error("disabled module did not take new settings");

	property p_apply_loads;
		@(posedge pclk) disable iff (!presetn)
		clk_en && apply && !wr_ctrl |=>
			st_q.div_act == $past(st_q.div) &&
			st_q.sel_act == $past(st_q.sel);
	endproperty
	a_apply_loads: assert property (p_apply_loads)
		else $error("switch did not load the written settings");

endmodule

// [verif/test_reference_clock_output_generator.sv]
`timescale 1ns/1ps

module test_reference_clock_output_generator;
	// ==========================================================
	// stimulus and observed signals
	logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, ref_clock_out_pin, ref_clock_out_oe;
	logic [31:0] prdata, r;
	logic idle_mode = 1'b0, sleep_mode = 1'b0, e;
	logic [15:0] src_clk_in = 16'h0;
	logic [2:0] cnt = 3'h0;
	logic [3:0] sels [3] = '{4'h2, 4'h1, 4'h0};
	int errors = 0, n_checks = 0, t, p;
	localparam logic [7:0] ON = 8'h80, STOP_IN_IDLE = 8'h20, OE = 8'h10;
	localparam logic [7:0] RUN_IN_SLEEP = 8'h08, SW = 8'h02;

	rco_ctrl u_rco_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
		.src_clk_in(src_clk_in), .ref_clock_out_pin(ref_clock_out_pin),
		.ref_clock_out_oe(ref_clock_out_oe));

	// ==========================================================
	// clocks: every source toggles each 4 pclk, period 8 pclk
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cnt <= cnt + 3'h1;
		src_clk_in <= {16{cnt[2]}};
	end

	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [31:0] s, x);
		n_checks++;
		if (s !== x) begin
			errors++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one apb transfer; an idle edge first keeps psel from double driving
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			errors++;
			$display("BAD pready exp 1 seen none");
			test_done();
		end
	endtask

	// off through the control lane alone; divider and source written
	// only once the request status reads zero
	task automatic cfg(input logic [14:0] dv, input logic [3:0] s,
		input logic [7:0] c);
		int k;
		k = 0;
		@(posedge pclk);
		pstrb <= 4'h2;
		apb(1'b1, 12'h000, 32'h0);
		pstrb <= 4'hF;
		do begin
			apb(1'b0, 12'h000, 32'h0);
			k++;
		end while (r[8] !== 1'b0 && k < 8);
		if (r[8] !== 1'b0) begin
			errors++;
			$display("BAD active exp 0 seen 1");
			test_done();
		end
		apb(1'b1, 12'h000, {1'b0, dv, 8'h00, 4'h0, s});
		apb(1'b1, 12'h000, {1'b0, dv, c, 4'h0, s});
	endtask

	// pin sampled on falling edges, where it has settled
	task automatic tog(input int n);
		logic pv;
		@(negedge pclk);
		pv = ref_clock_out_pin;
		t = 0;
		repeat (n) begin
			@(negedge pclk);
			if (ref_clock_out_pin !== pv)
				t++;
			pv = ref_clock_out_pin;
		end
		@(posedge pclk);
	endtask

	task automatic wait_rise(output int k);
		logic pv;
		k = 0;
		do begin
			pv = ref_clock_out_pin;
			@(negedge pclk);
			k++;
		end while (!(pv === 1'b0 && ref_clock_out_pin === 1'b1) && k < 4000);
		if (k >= 4000) begin
			errors++;
			$display("BAD pin rise exp edge seen none");
			test_done();
		end
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("reset", r, 32'h0);
		chk("reset oe", 32'(ref_clock_out_oe), 32'h0);
		apb(1'b1, 12'h004, 32'hFFFF_FFFF);
		chk("bad wr err", 32'(e), 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("bad rd err", 32'(e), 32'h1);
		chk("bad rd data", r, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("bad wr kept out", r, 32'h0);
		$display("test bus done");
		pstrb <= 4'h1;
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk("lane 0", r, 32'h0000_000F);
		pstrb <= 4'hF;
		apb(1'b1, 12'h000, 32'hFFFF_FDFF);
		apb(1'b0, 12'h000, 32'h0);
		chk("all ones", r, 32'h7FFF_B90F);
		apb(1'b1, 12'h000, 32'h0);
		tog(4);
		apb(1'b0, 12'h000, 32'h0);
		chk("idle active", r, 32'h0);
		$display("test fields done");
		for (int i = 1; i <= 3; i += 2) begin
			cfg(15'(i), 4'h2, ON | OE);
			wait_rise(p);
			wait_rise(p);
			chk("period", 32'(p), 32'(16 * i));
			chk("oe on", 32'(ref_clock_out_oe), 32'h1);
		end
		@(posedge pclk);
		clk_en <= 1'b0;
		tog(64);
		chk("frozen", 32'(t), 32'h0);
		clk_en <= 1'b1;
		cfg(15'd1, 4'h2, ON);
		tog(64);
		chk("oe off pin", 32'(t), 32'h0);
		chk("oe off", 32'(ref_clock_out_oe), 32'h0);
		cfg(15'd1, 4'h2, OE);
		tog(64);
		chk("disabled", 32'(t), 32'h0);
		$display("test output done");
		cfg(15'd1, 4'h2, ON | OE | STOP_IN_IDLE);
		idle_mode <= 1'b1;
		tog(8);
		tog(64);
		chk("idle stop", 32'(t), 32'h0);
		cfg(15'd1, 4'h2, ON | OE);
		tog(64);
		chk("idle run", 32'(t != 0), 32'h1);
		idle_mode <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			cfg(15'd1, sels[i / 2], ON | OE | ((i % 2 == 0) ? RUN_IN_SLEEP : 8'h00));
			sleep_mode <= 1'b1;
			tog(8);
			tog(64);
			chk("sleep", 32'(t != 0), 32'(i % 2 == 0 && i < 2));
			sleep_mode <= 1'b0;
		end
		$display("test modes done");
		cfg(15'h7FFF, 4'h2, ON | OE | STOP_IN_IDLE);
		apb(1'b1, 12'h000, {1'b0, 15'd1, ON | OE | STOP_IN_IDLE, 4'h0, 4'h2});
		apb(1'b0, 12'h000, 32'h0);
		chk("no switch", 32'(r[9]), 32'h0);
		tog(64);
		chk("old divider", 32'(t), 32'h0);
		apb(1'b1, 12'h000, {1'b0, 15'd1, ON | OE | STOP_IN_IDLE | SW, 4'h0, 4'h2});
		apb(1'b0, 12'h000, 32'h0);
		chk("switch pend", 32'(r[9]), 32'h1);
		idle_mode <= 1'b1;
		tog(4);
		apb(1'b0, 12'h000, 32'h0);
		chk("switch done", 32'(r[9]), 32'h0);
		idle_mode <= 1'b0;
		wait_rise(p);
		wait_rise(p);
		chk("new divider", 32'(p), 32'h10);
		$display("test switch done");
		test_done();
	end
endmodule
